// ---- hw/sp4_defines.svh ----
`ifndef SP4_DEFINES_SVH
`define SP4_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SP4_ADDR_CTRL     8'h98
`define SP4_ADDR_BUF      8'h99
`define SP4_ADDR_PWR      8'h87
`define SP4_ADDR_IRQ_STAT 8'ha0
`define SP4_ADDR_IRQ_CLR  8'ha1
`define SP4_ADDR_IRQ_EN   8'ha2

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SP4_CTRL_MODE_SEL0_OR_FRAME_ERR 7
`define SP4_CTRL_SM1    6
`define SP4_CTRL_MPE    5
`define SP4_CTRL_REN    4
`define SP4_CTRL_TB8    3
`define SP4_CTRL_RB8    2
`define SP4_CTRL_TI     1
`define SP4_CTRL_RI     0
`define SP4_PWR_DOUBLE  7
`define SP4_PWR_FESEL   6
`define SP4_IRQ_TX      0
`define SP4_IRQ_RX      1
`define SP4_IRQ_FE      2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SP4_RST_BYTE 8'h00
`define SP4_RST_IRQ  3'h0

// ------------------------------------------------------------
// Timing counts, in system clocks; oversample count and sample point in oversample ticks
// ------------------------------------------------------------
`define SP4_M0_SLOW_DIV 12
`define SP4_M0_FAST_DIV 4
`define SP4_M2_SLOW_BIT 64
`define SP4_M2_FAST_BIT 32
`define SP4_OVERSAMPLE  16
`define SP4_SAMPLE_POS  4'h7

`endif

// ---- hw/sp4_pkg.sv ----
package sp4_pkg;

  typedef enum logic [1:0] {
    SP4_MODE0,
    SP4_MODE1,
    SP4_MODE2,
    SP4_MODE3
  } sp4_mode_t;

  typedef enum logic [1:0] {
    SP4_TX_IDLE,
    SP4_TX_SYNC,
    SP4_TX_ASYNC
  } sp4_tx_state_t;

  typedef enum logic {
    SP4_RX_IDLE,
    SP4_RX_FRAME
  } sp4_rx_state_t;

endpackage

// ---- hw/sp4_sync.sv ----
`timescale 1ns/10ps

module sp4_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = d_in;
    sync_d = meta_q;
  end

  // Idle line level is high
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_out = sync_q;

endmodule

// ---- hw/sp4_tick_gen.sv ----
`timescale 1ns/10ps
`include "sp4_defines.svh"

module sp4_tick_gen (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] mode,
  input  wire logic       fast,
  input  wire logic       dbl,
  input  wire logic       timer_ovf,
  input  wire logic       m0_run,
  output logic            half_tick,
  output logic            os_tick
);

  logic [2:0] m0_cnt_q;
  logic [2:0] m0_cnt_d;
  logic [2:0] m0_lim;
  logic [2:0] os_cnt_q;
  logic [2:0] os_cnt_d;
  logic [2:0] os_lim;
  logic       os_step;

  // ------------------------------------------------------------
  // Shift clock half periods and oversample ticks
  // ------------------------------------------------------------
  always_comb
  begin
    m0_lim = fast ? 3'(`SP4_M0_FAST_DIV / 2) : 3'(`SP4_M0_SLOW_DIV / 2);
    // Held at zero between frames so every shift clock phase is full length
    m0_cnt_d = 3'h0;
    if (m0_run && m0_cnt_q != m0_lim - 3'h1)
    begin
      m0_cnt_d = m0_cnt_q + 3'h1;
    end
    half_tick = m0_run && (m0_cnt_q == m0_lim - 3'h1);
    if (mode == 2'h2)
    begin
      os_lim  = dbl ? 3'(`SP4_M2_FAST_BIT / `SP4_OVERSAMPLE)
                    : 3'(`SP4_M2_SLOW_BIT / `SP4_OVERSAMPLE);
      os_step = 1'b1;
    end
    else
    begin
      os_lim  = dbl ? 3'h1 : 3'h2;
      os_step = timer_ovf;
    end
    os_cnt_d = os_cnt_q;
    if (os_step)
    begin
      os_cnt_d = (os_cnt_q >= os_lim - 3'h1) ? 3'h0 : os_cnt_q + 3'h1;
    end
    os_tick = os_step && (os_cnt_q >= os_lim - 3'h1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m0_cnt_q <= 3'h0;
      os_cnt_q <= 3'h0;
    end
    else
    begin
      m0_cnt_q <= m0_cnt_d;
      os_cnt_q <= os_cnt_d;
    end
  end

endmodule

// ---- hw/sp4_serial_port.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "sp4_defines.svh"

// Operation
// - Control bit 7: mode bit or frame error
// - Frame error sticky until software clears
// - Mode bits pick frame length and rate
// - Modes 2/3 filter: ninth bit zero dropped
// - Mode 1 filter: bad stop dropped
// - Mode 0 shift clock divides 12 or 4
// - Receive only while receive permit set; mode 0 finishes a byte begun before permit clears
// - Ninth transmit bit set by software only
// - Receive ninth bit takes ninth or stop
// - Transmit done: bit 8 end or stop start
// - Receive done: bit 8 end or mid stop
// - Buffer: read receive, write transmit
// - Address recognition and framing error detection
// - Mode 1: start, eight data, stop
// - Mode 1 rate: overflow over 16 or 32
// - Mode 0 receive needs permit, flag clear
module sp4_serial_port (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       timer_ovf,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd_out,
  output logic            irq
);

  logic [1:0]               mode_q, mode_d;
  logic                     fe_q, fe_d, mpe_q, mpe_d, ren_q, ren_d;
  logic                     tb8_q, tb8_d, rb8_q, rb8_d, ti_q, ti_d, ri_q, ri_d;
  logic                     dbl_q, dbl_d, fesel_q, fesel_d;
  logic [7:0]               rx_buf_q, rx_buf_d, rd_data_q, rd_data_d;
  logic [2:0]               irq_st_q, irq_st_d, irq_en_q, irq_en_d;
  sp4_pkg::sp4_tx_state_t   tx_st_q, tx_st_d;
  logic [10:0]              tx_sh_q, tx_sh_d;
  logic [3:0]               tx_bit_q, tx_bit_d, tx_os_q, tx_os_d;
  logic                     ph_q, ph_d, m0rx_q, m0rx_d;
  sp4_pkg::sp4_rx_state_t   rx_st_q, rx_st_d;
  logic [8:0]               rx_sh_q, rx_sh_d;
  logic [3:0]               rx_bit_q, rx_bit_d, rx_os_q, rx_os_d;
  logic                     rx_prev_q;
  logic                     rxd_s, half_tick, os_tick;
  logic                     buf_wr, ctrl_wr, ti_set, ri_set, fe_set, m0_rx_done;
  logic                     accept, m1, m23;
  logic [3:0]               last_bit;
  logic [7:0]               rx_byte, ctrl_rd;
  sp4_pkg::sp4_mode_t       mode;

  sp4_sync u_rx_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d_in    (rxd_in),
    .q_out   (rxd_s)
  );

  sp4_tick_gen u_tick (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .mode      (mode_q),
    .fast      (mpe_q),
    .dbl       (dbl_q),
    .timer_ovf (timer_ovf),
    .m0_run    (tx_st_q == sp4_pkg::SP4_TX_SYNC),
    .half_tick (half_tick),
    .os_tick   (os_tick)
  );

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  always_comb
  begin
    mode     = sp4_pkg::sp4_mode_t'(mode_q);
    m1       = (mode == sp4_pkg::SP4_MODE1);
    m23      = (mode == sp4_pkg::SP4_MODE2) || (mode == sp4_pkg::SP4_MODE3);
    last_bit = m1 ? 4'h9 : 4'ha;
    buf_wr   = wr_en && (addr == `SP4_ADDR_BUF);
    ctrl_wr  = wr_en && (addr == `SP4_ADDR_CTRL);
  end

  // ------------------------------------------------------------
  // Transmitter and mode 0 shifter
  // ------------------------------------------------------------
  always_comb
  begin
    tx_st_d    = tx_st_q;
    tx_sh_d    = tx_sh_q;
    tx_bit_d   = tx_bit_q;
    tx_os_d    = tx_os_q;
    ph_d       = ph_q;
    m0rx_d     = m0rx_q;
    ti_set     = 1'b0;
    m0_rx_done = 1'b0;
    case (tx_st_q)
      sp4_pkg::SP4_TX_IDLE:
      begin
        tx_bit_d = 4'h0;
        tx_os_d  = 4'h0;
        ph_d     = 1'b0;
        if (buf_wr && mode == sp4_pkg::SP4_MODE0)
        begin
          tx_st_d = sp4_pkg::SP4_TX_SYNC;
          tx_sh_d = {3'b111, wr_data};
          m0rx_d  = 1'b0;
        end
        else if (buf_wr)
        begin
          tx_st_d = sp4_pkg::SP4_TX_ASYNC;
          // Frame is start, data LSB first, ninth bit in modes 2/3 only, stop
          tx_sh_d = m1 ? {2'b11, wr_data, 1'b0}
                       : {1'b1, tb8_q, wr_data, 1'b0};
        end
        else if (mode == sp4_pkg::SP4_MODE0 && ren_q && !ri_q)
        begin
          tx_st_d = sp4_pkg::SP4_TX_SYNC;
          tx_sh_d = 11'h000;
          m0rx_d  = 1'b1;
        end
      end
      sp4_pkg::SP4_TX_SYNC:
      begin
        if (half_tick && !ph_q)
        begin
          ph_d = 1'b1;
          if (m0rx_q)
          begin
            tx_sh_d = {3'b000, rxd_s, tx_sh_q[7:1]};
          end
        end
        else if (half_tick)
        begin
          ph_d     = 1'b0;
          tx_bit_d = tx_bit_q + 4'h1;
          if (!m0rx_q)
          begin
            tx_sh_d = {3'b111, 1'b1, tx_sh_q[7:1]};
          end
          if (tx_bit_q == 4'h7)
          begin
            tx_st_d    = sp4_pkg::SP4_TX_IDLE;
            ti_set     = !m0rx_q;
            m0_rx_done = m0rx_q;
          end
        end
      end
      sp4_pkg::SP4_TX_ASYNC:
      begin
        if (os_tick)
        begin
          tx_os_d = tx_os_q + 4'h1;
          if (tx_os_q == 4'hf)
          begin
            tx_sh_d  = {1'b1, tx_sh_q[10:1]};
            tx_bit_d = tx_bit_q + 4'h1;
            ti_set   = (tx_bit_q == last_bit - 4'h1);
            if (tx_bit_q == last_bit)
            begin
              tx_st_d = sp4_pkg::SP4_TX_IDLE;
            end
          end
        end
      end
      default:
      begin
        tx_st_d = sp4_pkg::SP4_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q  <= sp4_pkg::SP4_TX_IDLE;
      tx_sh_q  <= 11'h7ff;
      tx_bit_q <= 4'h0;
      tx_os_q  <= 4'h0;
      ph_q     <= 1'b0;
      m0rx_q   <= 1'b0;
    end
    else
    begin
      tx_st_q  <= tx_st_d;
      tx_sh_q  <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_os_q  <= tx_os_d;
      ph_q     <= ph_d;
      m0rx_q   <= m0rx_d;
    end
  end

  assign txd_out = (tx_st_q == sp4_pkg::SP4_TX_IDLE) ? 1'b1
                 : (tx_st_q == sp4_pkg::SP4_TX_SYNC) ? ph_q : tx_sh_q[0];
  assign rxd_oe  = (tx_st_q == sp4_pkg::SP4_TX_SYNC) && !m0rx_q;
  assign rxd_out = tx_sh_q[0];

  // ------------------------------------------------------------
  // Asynchronous receiver
  // ------------------------------------------------------------
  always_comb
  begin
    rx_st_d  = rx_st_q;
    rx_sh_d  = rx_sh_q;
    rx_bit_d = rx_bit_q;
    rx_os_d  = rx_os_q;
    fe_set   = 1'b0;
    ri_set   = m0_rx_done;
    accept   = 1'b0;
    rx_byte  = m1 ? rx_sh_q[8:1] : rx_sh_q[7:0];
    case (rx_st_q)
      sp4_pkg::SP4_RX_IDLE:
      begin
        // Start edge aligns the sample point; no edge search while busy
        if (mode != sp4_pkg::SP4_MODE0 && ren_q && rx_prev_q && !rxd_s)
        begin
          rx_st_d  = sp4_pkg::SP4_RX_FRAME;
          rx_os_d  = 4'h0;
          rx_bit_d = 4'h0;
        end
      end
      sp4_pkg::SP4_RX_FRAME:
      begin
        if (!ren_q || mode == sp4_pkg::SP4_MODE0)
        begin
          rx_st_d = sp4_pkg::SP4_RX_IDLE;
        end
        else if (os_tick)
        begin
          rx_os_d = rx_os_q + 4'h1;
          if (rx_os_q == `SP4_SAMPLE_POS)
          begin
            rx_bit_d = rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && rxd_s)
            begin
              rx_st_d = sp4_pkg::SP4_RX_IDLE;
            end
            else if (rx_bit_q == last_bit)
            begin
              rx_st_d = sp4_pkg::SP4_RX_IDLE;
              fe_set  = !rxd_s;
              accept  = !ri_q && !(mpe_q && ((m23 && !rx_sh_q[8]) ||
                                            (m1 && !rxd_s)));
              ri_set  = accept;
            end
            else if (rx_bit_q != 4'h0)
            begin
              rx_sh_d = {rxd_s, rx_sh_q[8:1]};
            end
          end
        end
      end
      default:
      begin
        rx_st_d = sp4_pkg::SP4_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q   <= sp4_pkg::SP4_RX_IDLE;
      rx_sh_q   <= 9'h000;
      rx_bit_q  <= 4'h0;
      rx_os_q   <= 4'h0;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_st_q   <= rx_st_d;
      rx_sh_q   <= rx_sh_d;
      rx_bit_q  <= rx_bit_d;
      rx_os_q   <= rx_os_d;
      rx_prev_q <= rxd_s;
    end
  end

  // ------------------------------------------------------------
  // Registers; hardware set beats a software clear
  // ------------------------------------------------------------
  always_comb
  begin
    {mode_d, fe_d, mpe_d, ren_d} = {mode_q, fe_q, mpe_q, ren_q};
    {tb8_d, rb8_d, ti_d, ri_d}   = {tb8_q, rb8_q, ti_q, ri_q};
    {dbl_d, fesel_d}             = {dbl_q, fesel_q};
    rx_buf_d = rx_buf_q;
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    if (ctrl_wr)
    begin
      if (fesel_q)
      begin
        fe_d = wr_data[`SP4_CTRL_MODE_SEL0_OR_FRAME_ERR];
      end
      else
      begin
        mode_d[1] = wr_data[`SP4_CTRL_MODE_SEL0_OR_FRAME_ERR];
      end
      mode_d[0] = wr_data[`SP4_CTRL_SM1];
      mpe_d     = wr_data[`SP4_CTRL_MPE];
      ren_d     = wr_data[`SP4_CTRL_REN];
      tb8_d     = wr_data[`SP4_CTRL_TB8];
      rb8_d     = wr_data[`SP4_CTRL_RB8];
      ti_d      = wr_data[`SP4_CTRL_TI];
      ri_d      = wr_data[`SP4_CTRL_RI];
    end
    if (wr_en && addr == `SP4_ADDR_PWR)
    begin
      dbl_d   = wr_data[`SP4_PWR_DOUBLE];
      fesel_d = wr_data[`SP4_PWR_FESEL];
    end
    if (wr_en && addr == `SP4_ADDR_IRQ_EN)
    begin
      irq_en_d = wr_data[2:0];
    end
    if (wr_en && addr == `SP4_ADDR_IRQ_CLR)
    begin
      irq_st_d = irq_st_q & ~wr_data[2:0];
    end
    irq_st_d = irq_st_d | {fe_set, ri_set, ti_set};
    fe_d     = fe_d | fe_set;
    ti_d     = ti_d | ti_set;
    ri_d     = ri_d | ri_set;
    if (m0_rx_done)
    begin
      rx_buf_d = tx_sh_q[7:0];
    end
    else if (accept)
    begin
      rx_buf_d = rx_byte;
      rb8_d    = m1 ? rxd_s : rx_sh_q[8];
    end
    ctrl_rd = {fesel_q ? fe_q : mode_q[1], mode_q[0], mpe_q, ren_q,
               tb8_q, rb8_q, ti_q, ri_q};
    case (addr)
      `SP4_ADDR_CTRL:     rd_data_d = ctrl_rd;
      `SP4_ADDR_BUF:      rd_data_d = rx_buf_q;
      `SP4_ADDR_PWR:      rd_data_d = {dbl_q, fesel_q, 6'h00};
      `SP4_ADDR_IRQ_STAT: rd_data_d = {5'h00, irq_st_q};
      `SP4_ADDR_IRQ_EN:   rd_data_d = {5'h00, irq_en_q};
      default:            rd_data_d = 8'h00;
    endcase
    if (!rd_en)
    begin
      rd_data_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {mode_q, fe_q, mpe_q, ren_q} <= 5'h00;
      {tb8_q, rb8_q, ti_q, ri_q}   <= 4'h0;
      {dbl_q, fesel_q}             <= 2'h0;
      rx_buf_q  <= `SP4_RST_BYTE;
      rd_data_q <= `SP4_RST_BYTE;
      irq_st_q  <= `SP4_RST_IRQ;
      irq_en_q  <= `SP4_RST_IRQ;
    end
    else
    begin
      {mode_q, fe_q, mpe_q, ren_q} <= {mode_d, fe_d, mpe_d, ren_d};
      {tb8_q, rb8_q, ti_q, ri_q}   <= {tb8_d, rb8_d, ti_d, ri_d};
      {dbl_q, fesel_q}             <= {dbl_d, fesel_d};
      rx_buf_q  <= rx_buf_d;
      rd_data_q <= rd_data_d;
      irq_st_q  <= irq_st_d;
      irq_en_q  <= irq_en_d;
    end
  end

  assign rd_data = rd_data_q;
  assign irq     = |(irq_st_q & irq_en_q);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  fe_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fe_q && !ctrl_wr |=> fe_q) else $error("frame error lost");
  ctrl_bit7_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_en && addr == `SP4_ADDR_CTRL && fesel_q |=> rd_data[7] == $past(fe_q))
    else $error("bit 7 not frame error");
  permit_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ren_q && rx_st_q == sp4_pkg::SP4_RX_IDLE |=> rx_st_q == sp4_pkg::SP4_RX_IDLE)
    else $error("receive without permit");
  ti_at_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ti_q) && tx_st_q == sp4_pkg::SP4_TX_ASYNC |-> txd_out && tx_bit_q == last_bit)
    else $error("transmit done not at stop");
  mp_ninth_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ri_q) && mpe_q && m23 |-> rb8_q) else $error("ninth bit filter");
  mp_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ri_q) && mpe_q && m1 |-> rb8_q) else $error("stop bit filter");
  fast_clk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(txd_out) && mode == sp4_pkg::SP4_MODE0 && mpe_q |=> !txd_out ##1 txd_out)
    else $error("fast shift clock");
  slow_clk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(txd_out) && mode == sp4_pkg::SP4_MODE0 && !mpe_q |=> !txd_out [*5] ##1 txd_out)
    else $error("slow shift clock");
  buf_split_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    buf_wr && !accept && !m0_rx_done |=> rx_buf_q == $past(rx_buf_q))
    else $error("write reached receive buffer");
  m0_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == sp4_pkg::SP4_MODE0 && ri_q && !buf_wr && tx_st_q == sp4_pkg::SP4_TX_IDLE
    |=> tx_st_q == sp4_pkg::SP4_TX_IDLE) else $error("mode 0 receive with flag set");

endmodule

// ---- test/sp4_remote.sv ----
`timescale 1ns/10ps

// ------------------------------
// Far-side serial device
// ------------------------------
module sp4_remote (
  input  wire logic sys_clk,
  input  wire logic txd_out,
  input  wire logic rxd_out,
  output logic      rx_line
);
  int stalls;

  // Line has a pull-up, so idle and released read high
  initial
  begin
    rx_line = 1'b1;
    stalls  = 0;
  end

  // Bounded wait for a level on the transmit pin
  task automatic wait_txd(input logic lv, inout int cnt);
    int w;
    w = 0;
    while (txd_out !== lv)
    begin
      @(posedge sys_clk);
      #1;
      w++;
      if (w > 2000)
      begin
        stalls++;
        return;
      end
    end
    cnt += w;
  endtask

  // Frame out LSB first, start bit in bit 0
  task automatic send_async(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= bits[i];
      repeat (per) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
  endtask

  // Mid-bit sampling copes with a start bit cut short by tick phase
  task automatic recv_async(input int n, input int per, output logic [10:0] bits);
    int c;
    c = 0;
    bits = '0;
    wait_txd(1'b0, c);
    repeat (per / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txd_out;
      repeat (per) @(posedge sys_clk);
    end
  endtask

  // Mode 0 capture on rising shift clock; period from first two rises
  task automatic m0_capture(output logic [7:0] d, output int per);
    int c;
    c = 0;
    per = 0;
    for (int i = 0; i < 8; i++)
    begin
      wait_txd(1'b0, c);
      wait_txd(1'b1, c);
      d[i] = rxd_out;
      if (i == 1)
        per = c;
      c = 0;
    end
  endtask

  // Mode 0 data presented on falling shift clock, LSB first
  task automatic m0_send(input logic [7:0] d);
    int c;
    c = 0;
    for (int i = 0; i < 8; i++)
    begin
      wait_txd(1'b0, c);
      rx_line <= d[i];
      wait_txd(1'b1, c);
    end
    rx_line <= 1'b1;
  endtask
endmodule

// ---- test/serial_port_four_mode_tb.sv ----
`timescale 1ns/10ps
`include "sp4_defines.svh"

module serial_port_four_mode_tb;
  localparam logic [7:0] CTL  = `SP4_ADDR_CTRL;
  localparam logic [7:0] BUF  = `SP4_ADDR_BUF;
  localparam logic [7:0] PWR  = `SP4_ADDR_PWR;
  localparam logic [7:0] IST  = `SP4_ADDR_IRQ_STAT;
  localparam logic [7:0] ICLR = `SP4_ADDR_IRQ_CLR;
  localparam logic [7:0] IEN  = `SP4_ADDR_IRQ_EN;

  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        timer_ovf;
  logic        rxd_in;
  logic        rxd_out;
  logic        rxd_oe;
  logic        txd_out;
  logic        irq;
  logic        rx_line;
  logic [1:0]  ovf_cnt;
  logic [7:0]  rd_v;
  logic [7:0]  b;
  logic [10:0] fr;
  logic [7:0]  rx_q[$];
  int          per;
  int          miscompares;
  int          n_checks;
  logic [7:0]  rst_a[6] = '{CTL, BUF, PWR, IST, IEN, 8'h00};

  sp4_serial_port dut (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .addr      (addr),
    .wr_data   (wr_data),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .rd_data   (rd_data),
    .timer_ovf (timer_ovf),
    .rxd_in    (rxd_in),
    .rxd_out   (rxd_out),
    .rxd_oe    (rxd_oe),
    .txd_out   (txd_out),
    .irq       (irq)
  );

  sp4_remote rem (
    .sys_clk (sys_clk),
    .txd_out (txd_out),
    .rxd_out (rxd_out),
    .rx_line (rx_line)
  );

  // Receive pin: device drives it only in mode 0 transmit
  assign rxd_in = rxd_oe ? rxd_out : rx_line;

  always #2 sys_clk = ~sys_clk;

  // Overflow every 4 clocks; with doubling a bit lasts 64 clocks
  always @(posedge sys_clk)
  begin
    ovf_cnt   <= ovf_cnt + 2'h1;
    timer_ovf <= (ovf_cnt == 2'h3);
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {3'h0, rd_data}, {3'h0, exp});
  endtask

  task automatic irqc(input logic e);
    repeat (2) @(posedge sys_clk);
    #1;
    check("irq", {10'h0, irq}, {10'h0, e});
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  // ------------------------------
  // Sequence
  // ------------------------------
  initial
  begin
    sys_clk     = 1'b0;
    rst_n       = 1'b0;
    addr        = 8'h00;
    wr_data     = 8'h00;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    timer_ovf   = 1'b0;
    ovf_cnt     = 2'h0;
    miscompares = 0;
    n_checks    = 0;
    void'($urandom(32'habb2));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, then refused writes
    foreach (rst_a[i])
      rdc(rst_a[i], 8'h00);
    wr(8'h00, 8'hff);
    wr(IST, 8'h07);
    rdc(8'h00, 8'h00);
    rdc(IST, 8'h00);
    // Mode 1 receive, stop bit lands in the ninth-bit slot
    wr(PWR, 8'h80);
    wr(CTL, 8'h50);
    repeat (3)
    begin
      b = 8'($urandom);
      rx_q.push_back(b);
      rem.send_async({2'b11, b, 1'b0}, 10, 64);
      repeat (4) @(posedge sys_clk);
      rdc(CTL, 8'h55);
      rdc(BUF, rx_q.pop_front());
      wr(CTL, 8'h50);
    end
    // Bad stop with filtering on: dropped, frame error kept
    wr(ICLR, 8'h07);
    wr(CTL, 8'h70);
    rem.send_async({2'b10, 8'h5a, 1'b0}, 10, 64);
    repeat (4) @(posedge sys_clk);
    rdc(CTL, 8'h70);
    rdc(IST, 8'h04);
    wr(PWR, 8'hc0);
    rdc(CTL, 8'hf0);
    wr(CTL, 8'h70);
    rdc(CTL, 8'h70);
    wr(PWR, 8'h80);
    // Mode 3 address filtering on the ninth bit
    wr(CTL, 8'hf0);
    for (int n9 = 0; n9 < 2; n9++)
    begin
      b = 8'($urandom);
      rem.send_async({1'b1, n9[0], b, 1'b0}, 11, 64);
      repeat (4) @(posedge sys_clk);
      rdc(CTL, (n9 == 1) ? 8'hf5 : 8'hf0);
    end
    rdc(BUF, b);
    // Permit off: the line is ignored
    wr(CTL, 8'hc0);
    rem.send_async({2'b11, ~b, 1'b0}, 11, 64);
    repeat (4) @(posedge sys_clk);
    rdc(CTL, 8'hc0);
    rdc(BUF, b);
    // Mode 2 transmit at 64 clocks a bit, both ninth-bit values
    wr(PWR, 8'h00);
    wr(IEN, 8'h01);
    wr(ICLR, 8'h07);
    for (int t8 = 0; t8 < 2; t8++)
    begin
      wr(CTL, (t8 == 1) ? 8'h88 : 8'h80);
      b = 8'($urandom);
      wr(BUF, b);
      rem.recv_async(11, 64, fr);
      check("tx frame", fr, {1'b1, t8[0], b, 1'b0});
      rdc(CTL, (t8 == 1) ? 8'h8a : 8'h82);
    end
    irqc(1'b1);
    wr(IEN, 8'h00);
    irqc(1'b0);
    wr(IEN, 8'h01);
    irqc(1'b1);
    wr(ICLR, 8'h01);
    irqc(1'b0);
    // Mode 0 transmit at both shift rates
    for (int m = 0; m < 2; m++)
    begin
      wr(CTL, (m == 1) ? 8'h20 : 8'h00);
      b = 8'($urandom);
      wr(BUF, b);
      rem.m0_capture(rd_v, per);
      check("m0 byte", {3'h0, rd_v}, {3'h0, b});
      check("m0 period", 11'(per), (m == 1) ? 11'h4 : 11'hc);
      // Done flag follows the last high half, up to 6 clocks after the last rise
      repeat (8) @(posedge sys_clk);
      rdc(CTL, (m == 1) ? 8'h22 : 8'h02);
    end
    // Mode 0 receive stops once its done flag is up
    wr(CTL, 8'h00);
    b = 8'($urandom);
    fork
      rem.m0_send(b);
      wr(CTL, 8'h10);
    join
    repeat (20) @(posedge sys_clk);
    rdc(BUF, b);
    rdc(CTL, 8'h11);
    check("stalls", 11'(rem.stalls), 11'h0);
    give_verdict();
  end
endmodule
